// ### iham_fifo.sv
/*
  Word FIFO with valid and ready on both sides.
  Assumes a power-of-two depth; both sides run on the same clock.
*/
`default_nettype none
module iham_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire logic push;
  wire logic pop;

  assign in_ready = count_r != (AW + 1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ### iham_pkg.sv
/*
  Shared constants and types of the two-wire host adapter and bus monitor.
  Assumes a 250 MHz core clock and a host link that hands over whole bytes.
*/
// Notes on behaviour
// - Reads clock in each byte, acknowledge all but the last, NACK the last.
// - Write bytes go out in order to the target chosen by the last start.
// - Register read writes a one-byte index, then reads the same target back.
// - Register write sends the address, a one-byte index, then the value bytes.
// - A stop request puts a stop condition on the bus and ends the transfer.
// - Monitor mode never drives the bus; it only decodes traffic for the display.
// - The host enters monitor mode with the single monitor command byte.
// - In monitor mode any further host byte returns the block to driver mode.
// - Capture mode never drives the bus and streams observed events to the host; an event that finds the FIFO full is dropped and sets cap_overflow.
// - Capture mode shows the capture symbol as the mode character.
// - Activity map of 112 addresses; active white, fading yellow, purple, blue.
// - Decoder shows start, address with direction, data bytes with ACK or NACK, stop.
// - A NACK on the final byte of a read is not flagged as an error.
// - Both bus lines are presented live as waveform traces.
// - Command bytes 0x80 to 0xbf read 1 to 64 bytes and NACK the final one.
// - Start command plus address byte makes a start, sends the byte, returns the ACK.
`default_nettype none
package iham_pkg;
  localparam int CLK_MHZ = 250;
  localparam int I2C_QTR_NS = 2500;
  localparam int I2C_QTR_CYC = (I2C_QTR_NS * CLK_MHZ + 999) / 1000;
  localparam int HEAT_STEP_MS = 100;
  localparam int HEAT_STEP_CYC = HEAT_STEP_MS * 1000 * CLK_MHZ;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 11;
  localparam int HEAT_ADDRS = 112;
  localparam logic [6:0] ADDR_FIRST = 7'h08;
  localparam logic [6:0] ADDR_LAST = 7'h77;
  localparam logic [1:0] HEAT_WHITE = 2'h3;
  localparam logic [1:0] HEAT_BLUE = 2'h0;
  localparam logic [7:0] CMD_MON = 8'h6d;
  localparam logic [7:0] CMD_CAP = 8'h63;
  localparam logic [7:0] CMD_START = 8'h73;
  localparam logic [7:0] CMD_STOP = 8'h70;
  localparam logic [7:0] CMD_REGRD = 8'h72;
  localparam logic [7:0] CMD_REGWR = 8'h67;
  localparam logic [1:0] CMD_RD_TOP = 2'h2;
  localparam logic [1:0] CMD_WR_TOP = 2'h3;
  localparam logic [7:0] CH_DRV = 8'h44;
  localparam logic [7:0] CH_MON = 8'h4d;
  localparam logic [7:0] CH_CAP = 8'h43;
  localparam logic [1:0] KIND_REPLY = 2'h0;
  localparam logic [1:0] KIND_START = 2'h1;
  localparam logic [1:0] KIND_BYTE = 2'h2;
  localparam logic [1:0] KIND_STOP = 2'h3;
  typedef enum logic [1:0] {M_DRV, M_MON, M_CAP} iham_mode_t;
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} iham_op_t;
  typedef enum logic [3:0] {S_IDLE, S_ARG, S_START, S_ADDR, S_REG, S_RSTART, S_RADDR,
                            S_READ, S_WRB, S_WRITE, S_STOP} iham_st_t;
endpackage
`default_nettype wire

// ### iham_tgt.sv
/*
  Two-wire target model: one address, 256-byte memory, clock stretch after each ack.
  Assumes the bench joins its pulls into wired-and lines that idle high.
*/
`default_nettype none
module iham_tgt #(
  parameter logic [6:0] ADDR = 7'h45
) (
  input wire logic clk,
  input wire logic sda,
  input wire logic scl,
  input wire logic [15:0] stretch,
  output logic sda_low,
  output logic scl_low,
  output logic last_ack,
  output logic stop_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr;
  logic sel, rd, adr, first, snd;
  int bc;
  initial
  begin
    sda_low = 0;
    scl_low = 0;
    snd = 0;
    sel = 0;
    bc = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      bc = 0;
      adr = 1;
      first = 1;
      snd = 0;
      stop_seen = 0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      stop_seen = 1;
  always @(posedge scl)
  begin
    if (bc < 8)
      sh = {sh[6:0], sda};
    else
      last_ack = sda;
    bc = bc + 1;
  end
  // Data only changes while the clock is low, so the controller never sees a false start
  always @(negedge scl)
  begin
    if (bc == 8)
    begin
      if (adr)
        {sel, rd} = {sh[7:1] == ADDR, sh[0]};
      else if (sel && !rd && first)
        ptr = sh;
      else if (sel && !rd)
      begin
        mem[ptr] = sh;
        ptr++;
      end
      first = adr;
      sda_low = sel && (adr || !rd);
    end
    else if (bc == 9)
    begin
      bc = 0;
      snd = sel && rd && (adr || !last_ack);
      adr = 0;
      tx = mem[ptr];
      if (snd)
        ptr++;
      sda_low = snd && !tx[7];
      scl_low = sel;
      repeat (sel ? stretch : 16'h0000) @(posedge clk);
      scl_low = 0;
    end
    else if (snd)
      sda_low = !tx[7 - bc];
  end
endmodule
`default_nettype wire

// ### iham_top.sv
/*
  Two-wire bus controller driven by host command bytes, with passive monitor and
  capture modes, bus event decoder, activity map and waveform taps.
  Assumes host bytes arrive already deserialised on the core clock, and that the
  bus lines are pulled up outside; sda and scl inputs are asynchronous.
*/
`default_nettype none
module iham_top
  import iham_pkg::*;
#(
  parameter int HEAT_TICK_CYC = HEAT_STEP_CYC,
  // Lets a bench shorten the bit time; the default keeps the bus at 100 kHz
  parameter int QTR_CYC = I2C_QTR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_data,
  output logic host_rx_ready,
  output logic host_tx_valid,
  output logic [1:0] host_tx_kind,
  output logic host_tx_ack,
  output logic [7:0] host_tx_data,
  input wire logic host_tx_ready,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  output logic [7:0] mode_char,
  output logic [HEAT_ADDRS-1:0][1:0] heat_map,
  output logic dec_valid,
  output logic [1:0] dec_kind,
  output logic [7:0] dec_data,
  output logic dec_ack,
  output logic dec_err,
  output logic wave_sda,
  output logic wave_scl,
  output logic cap_overflow
);
  localparam int QW = $clog2(QTR_CYC);
  localparam int HW = $clog2(HEAT_TICK_CYC);

  function automatic logic [7:0] mode_symbol(input iham_mode_t m);
    case (m)
      M_MON: mode_symbol = CH_MON;
      M_CAP: mode_symbol = CH_CAP;
      default: mode_symbol = CH_DRV;
    endcase
  endfunction

  // Bus line synchronisers and waveform taps
  logic sda_m_r, sda_s_r, sda_d_r, scl_m_r, scl_s_r, scl_d_r;
  // Mode, command sequencer and engine state
  iham_mode_t mode_r, mode_nxt;
  iham_st_t st_r, st_nxt;
  logic [7:0] cmd_r, dev_r, reg_r, cnt_r, wb_r, char_r;
  logic [1:0] argn_r;
  logic issued_r, rx_ready_r, sda_oe_n_r, scl_oe_n_r, ovf_r;
  logic run_r, samp_r, nack_r, ackbit_r;
  iham_op_t op_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [QW-1:0] qcnt_r;
  logic lvl_sda_low, lvl_scl_low;
  iham_op_t go_op;
  logic [7:0] go_byte;
  // Decoder, map and host output stage
  logic dact_r, dfirst_r, drw_r;
  logic [3:0] dbits_r;
  logic [7:0] dshift_r;
  logic dv_r, dack_r, derr_r;
  logic [1:0] dkind_r;
  logic [7:0] ddata_r;
  logic [HEAT_ADDRS-1:0][1:0] heat_r;
  logic [HW-1:0] hcnt_r;
  logic tx_valid_r;
  logic [FIFO_WIDTH-1:0] tx_word_r;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_in_data, fifo_out_data;

  wire logic rx_take = host_rx_valid && rx_ready_r;
  wire logic op_state = st_r inside {S_START, S_ADDR, S_REG, S_RSTART, S_RADDR, S_READ,
                                     S_WRITE, S_STOP};
  // Every op waits for FIFO room so a reply can never be dropped
  wire logic eng_go = op_state && !issued_r && !run_r && fifo_in_ready;
  wire logic qend = qcnt_r == QW'(QTR_CYC - 1);
  // A target stretching the clock holds the high phase open
  wire logic qtick = run_r && qend && (phase_r != 2'd1 || scl_s_r);
  wire logic bits_op = op_r == OP_WRITE || op_r == OP_READ;
  wire logic eng_done = qtick && phase_r == 2'd3 && (!bits_op || bit_r == 4'd8);
  wire logic [7:0] rx_byte = {shift_r[6:0], samp_r};
  wire logic reply_push = eng_done && ((st_r == S_ADDR && cmd_r == CMD_START) ||
                                       st_r == S_READ);
  wire logic [7:0] reply_data = st_r == S_READ ? shift_r : {7'h00, samp_r};
  // Bus decoder edges use only the second and third stages
  wire logic start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  wire logic stop_det = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  wire logic scl_rise = scl_s_r && !scl_d_r;
  wire logic byte_done = dact_r && scl_rise && dbits_r == 4'd8;
  wire logic ev_valid = byte_done || (stop_det && dact_r);
  wire logic [1:0] ev_kind = !byte_done ? KIND_STOP : (dfirst_r ? KIND_START : KIND_BYTE);
  wire logic [7:0] ev_data = byte_done ? dshift_r : 8'h00;
  wire logic ev_ack = byte_done && sda_s_r;
  wire logic [6:0] ev_addr = dshift_r[7:1];
  wire logic addr_legal = ev_addr >= ADDR_FIRST && ev_addr <= ADDR_LAST;
  wire logic heat_tick = hcnt_r == HW'(HEAT_TICK_CYC - 1);
  wire logic cap_push = ev_valid && mode_r == M_CAP;

  assign fifo_in_valid = reply_push || cap_push;
  assign fifo_in_data = cap_push ? {ev_kind, ev_ack, ev_data}
                                 : {KIND_REPLY, samp_r, reply_data};
  assign fifo_out_ready = !tx_valid_r || host_tx_ready;

  iham_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Engine operation chosen by the sequencer state
  always_comb
  begin
    go_op = OP_WRITE;
    go_byte = dev_r;
    case (st_r)
      S_START, S_RSTART: go_op = OP_START;
      S_STOP: go_op = OP_STOP;
      S_READ: go_op = OP_READ;
      S_REG: go_byte = reg_r;
      S_RADDR: go_byte = {dev_r[7:1], 1'b1};
      S_WRITE: go_byte = wb_r;
      default: go_byte = dev_r;
    endcase
  end

  // Line levels per quarter of a bit
  always_comb
  begin
    lvl_sda_low = !sda_oe_n_r;
    lvl_scl_low = !scl_oe_n_r;
    if (run_r)
    begin
      lvl_scl_low = phase_r == 2'd0 || phase_r == 2'd3;
      case (op_r)
        OP_START: lvl_sda_low = phase_r[1];
        OP_STOP:
        begin
          lvl_sda_low = !phase_r[1];
          lvl_scl_low = phase_r == 2'd0;
        end
        default:
          lvl_sda_low = bit_r == 4'd8 ? (op_r == OP_READ && !ackbit_r)
                                      : (op_r == OP_WRITE && !shift_r[7]);
      endcase
    end
  end

  // Command sequencer
  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    if (rx_take && st_r == S_IDLE)
    begin
      if (mode_r != M_DRV)
        mode_nxt = M_DRV;
      else if (host_rx_data == CMD_MON)
        mode_nxt = M_MON;
      else if (host_rx_data == CMD_CAP)
        mode_nxt = M_CAP;
      else if (host_rx_data inside {CMD_START, CMD_REGRD, CMD_REGWR})
        st_nxt = S_ARG;
      else if (host_rx_data == CMD_STOP)
        st_nxt = S_STOP;
      else if (host_rx_data[7:6] == CMD_RD_TOP)
        st_nxt = S_READ;
      else if (host_rx_data[7:6] == CMD_WR_TOP)
        st_nxt = S_WRB;
    end
    else if (rx_take && st_r == S_ARG && argn_r == 2'd1)
      st_nxt = S_START;
    else if (rx_take && st_r == S_WRB)
      st_nxt = S_WRITE;
    else if (eng_done)
    begin
      case (st_r)
        S_START: st_nxt = S_ADDR;
        S_ADDR: st_nxt = cmd_r == CMD_START ? S_IDLE : S_REG;
        S_REG: st_nxt = cmd_r == CMD_REGRD ? S_RSTART : S_WRB;
        S_RSTART: st_nxt = S_RADDR;
        S_RADDR: st_nxt = S_READ;
        S_READ, S_WRITE:
          if (cnt_r == 8'd1)
            st_nxt = cmd_r inside {CMD_REGRD, CMD_REGWR} ? S_STOP : S_IDLE;
          else
            st_nxt = st_r == S_READ ? S_READ : S_WRB;
        default: st_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {sda_m_r, sda_s_r, sda_d_r, scl_m_r, scl_s_r, scl_d_r} <= 6'h3f;
      mode_r <= M_DRV;
      st_r <= S_IDLE;
      char_r <= CH_DRV;
      rx_ready_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
      {cmd_r, dev_r, reg_r, cnt_r, wb_r} <= 40'h00_0000_0000;
      argn_r <= 2'h0;
      issued_r <= 1'b0;
      ovf_r <= 1'b0;
    end
    else
    begin
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
      mode_r <= mode_nxt;
      st_r <= st_nxt;
      char_r <= mode_symbol(mode_nxt);
      rx_ready_r <= st_nxt inside {S_IDLE, S_ARG, S_WRB};
      // Passive modes release both lines at once
      sda_oe_n_r <= !(lvl_sda_low && mode_nxt == M_DRV);
      scl_oe_n_r <= !(lvl_scl_low && mode_nxt == M_DRV);
      if (eng_go)
        issued_r <= 1'b1;
      else if (eng_done)
        issued_r <= 1'b0;
      if (rx_take && st_r == S_IDLE)
      begin
        cmd_r <= host_rx_data;
        argn_r <= host_rx_data == CMD_START ? 2'd1 : 2'd3;
        cnt_r <= {2'b00, host_rx_data[5:0]} + 8'd1;
      end
      if (rx_take && st_r == S_ARG)
      begin
        argn_r <= argn_r - 2'd1;
        if (cmd_r == CMD_START)
          dev_r <= host_rx_data;
        else if (argn_r == 2'd3)
          dev_r <= {host_rx_data[6:0], 1'b0};
        else if (argn_r == 2'd2)
          reg_r <= host_rx_data;
        else
          cnt_r <= host_rx_data == 8'h00 ? 8'd1 : host_rx_data;
      end
      if (rx_take && st_r == S_WRB)
        wb_r <= host_rx_data;
      if (eng_done && (st_r == S_READ || st_r == S_WRITE))
        cnt_r <= cnt_r - 8'd1;
      if (rx_take && st_r == S_IDLE && mode_r == M_DRV && host_rx_data == CMD_CAP)
        ovf_r <= 1'b0;
      else if (cap_push && !fifo_in_ready)
        ovf_r <= 1'b1;
    end
  end

  // Bit engine: four quarters per bit, sample at the end of the second high quarter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      run_r <= 1'b0;
      op_r <= OP_START;
      {phase_r, bit_r, qcnt_r} <= '0;
      {shift_r, samp_r, nack_r, ackbit_r} <= 11'h000;
    end
    else if (eng_go)
    begin
      run_r <= 1'b1;
      op_r <= go_op;
      {phase_r, bit_r, qcnt_r} <= '0;
      shift_r <= go_byte;
      ackbit_r <= cnt_r == 8'd1;
    end
    else if (run_r)
    begin
      qcnt_r <= qend ? qcnt_r : qcnt_r + QW'(1);
      if (qtick)
      begin
        qcnt_r <= '0;
        phase_r <= phase_r + 2'd1;
        if (phase_r == 2'd2)
          samp_r <= sda_s_r;
        if (phase_r == 2'd3 && bits_op && bit_r != 4'd8)
        begin
          shift_r <= rx_byte;
          bit_r <= bit_r + 4'd1;
        end
        if (phase_r == 2'd3 && bits_op && bit_r == 4'd8)
          nack_r <= samp_r;
        if (eng_done)
          run_r <= 1'b0;
      end
    end
  end

  // Passive decoder, runs in every mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {dact_r, dfirst_r, drw_r, dbits_r, dshift_r} <= 15'h0000;
      {dv_r, dack_r, derr_r, dkind_r, ddata_r} <= 13'h0000;
    end
    else
    begin
      dv_r <= ev_valid;
      dkind_r <= ev_kind;
      ddata_r <= ev_data;
      dack_r <= ev_ack;
      // Read data NACK is the normal end of a read
      derr_r <= byte_done && sda_s_r && (dfirst_r || !drw_r);
      if (start_det)
      begin
        {dact_r, dfirst_r, dbits_r} <= {2'b11, 4'h0};
      end
      else if (stop_det)
        dact_r <= 1'b0;
      else if (dact_r && scl_rise)
      begin
        if (dbits_r != 4'd8)
        begin
          dshift_r <= {dshift_r[6:0], sda_s_r};
          dbits_r <= dbits_r + 4'd1;
        end
        else
        begin
          dbits_r <= 4'h0;
          dfirst_r <= 1'b0;
          if (dfirst_r)
            drw_r <= dshift_r[0];
        end
      end
    end
  end

  // Activity map: a start touches white, each tick fades one step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      heat_r <= '0;
      hcnt_r <= '0;
    end
    else
    begin
      hcnt_r <= heat_tick ? '0 : hcnt_r + HW'(1);
      for (int i = 0; i < HEAT_ADDRS; i++)
      begin
        if (byte_done && dfirst_r && addr_legal && ev_addr - ADDR_FIRST == 7'(i))
          heat_r[i] <= HEAT_WHITE;
        else if (heat_tick && heat_r[i] != HEAT_BLUE)
          heat_r[i] <= heat_r[i] - 2'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid_r <= 1'b0;
      tx_word_r <= '0;
    end
    else if (fifo_out_ready)
    begin
      tx_valid_r <= fifo_out_valid;
      tx_word_r <= fifo_out_data;
    end
  end

  assign host_rx_ready = rx_ready_r;
  assign {host_tx_kind, host_tx_ack, host_tx_data} = tx_word_r;
  assign host_tx_valid = tx_valid_r;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign scl_oe_n = scl_oe_n_r;
  assign mode_char = char_r;
  assign heat_map = heat_r;
  assign {dec_valid, dec_kind, dec_data, dec_ack, dec_err} = {dv_r, dkind_r, ddata_r,
                                                              dack_r, derr_r};
  assign wave_sda = sda_s_r;
  assign wave_scl = scl_s_r;
  assign cap_overflow = ovf_r;

  a_passive_release: assert property (@(posedge clk) disable iff (rst)
    mode_r != M_DRV |-> sda_oe_n_r && scl_oe_n_r) else $error("bus driven in passive mode");
  a_mon_symbol: assert property (@(posedge clk) disable iff (rst)
    mode_r == M_MON |-> char_r == CH_MON) else $error("monitor symbol missing");
  a_cap_symbol: assert property (@(posedge clk) disable iff (rst)
    mode_r == M_CAP |-> char_r == CH_CAP) else $error("capture symbol missing");
  a_mon_leave: assert property (@(posedge clk) disable iff (rst)
    mode_r == M_MON && rx_take |=> mode_r == M_DRV && char_r == CH_DRV) else $error("monitor kept");
  a_cap_leave: assert property (@(posedge clk) disable iff (rst)
    mode_r == M_CAP && rx_take |=> mode_r == M_DRV ##0 char_r == CH_DRV) else $error("capture kept");
  a_read_last_nack: assert property (@(posedge clk) disable iff (rst)
    eng_go && st_r == S_READ |=> ackbit_r == (cnt_r == 8'd1)) else $error("wrong read ack");
  a_cap_event_push: assert property (@(posedge clk) disable iff (rst)
    ev_valid && mode_r == M_CAP && fifo_in_ready |-> fifo_in_valid && !reply_push) else $error("event lost");
  a_heat_white: assert property (@(posedge clk) disable iff (rst)
    byte_done && dfirst_r && addr_legal |=> heat_r[$past(ev_addr) - ADDR_FIRST] == HEAT_WHITE) else $error("map not lit");
  a_stop_release: assert property (@(posedge clk) disable iff (rst)
    eng_done && op_r == OP_STOP |=> sda_oe_n_r && scl_oe_n_r && st_r == S_IDLE) else $error("stop not released");
  a_read_no_err: assert property (@(posedge clk) disable iff (rst)
    byte_done && !dfirst_r && drw_r |=> dv_r && !derr_r) else $error("read nack flagged");
  c_capture_event: cover property (@(posedge clk) disable iff (rst) cap_push && fifo_in_ready);
  c_reg_read: cover property (@(posedge clk) disable iff (rst) st_r == S_RADDR ##[1:1000] st_r == S_READ);
  c_monitor_entry: cover property (@(posedge clk) disable iff (rst) mode_r == M_DRV ##1 mode_r == M_MON);
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Bench for the two-wire host adapter: driver transfers, monitor and capture modes.
  Assumes the target model and the pull-up resolution below stand in for the bus.
*/
`default_nettype none
module tb_top
  import iham_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] TA = 7'h45;
  logic clk = 0, rst = 1, host_rx_valid = 0, host_tx_ready = 0, b_sda = 0, b_scl = 0;
  logic passive = 0, ok;
  logic [7:0] host_rx_data = 8'h00, idx, ri, v1, v2;
  logic host_rx_ready, host_tx_valid, host_tx_ack, sda_oe_n, scl_oe_n, dec_valid, dec_ack;
  logic dec_err, wave_sda, wave_scl, cap_overflow, t_sda, t_scl, last_ack, stop_seen;
  logic [1:0] host_tx_kind, dec_kind;
  logic [7:0] host_tx_data, mode_char, dec_data;
  logic [HEAT_ADDRS-1:0][1:0] heat_map;
  logic [10:0] wd;
  logic [11:0] dq[$], eq[$];
  int bad_count = 0, n_tests = 0, seed = 32'h0e017935;
  // Pull-ups: a released line reads high, never its last driven value
  wire sda_w = !(!sda_oe_n || t_sda || b_sda);
  wire scl_w = !(!scl_oe_n || t_scl || b_scl);
  always #2 clk = ~clk;
  iham_top #(.HEAT_TICK_CYC(1000), .QTR_CYC(8)) uut (.clk, .rst, .host_rx_valid, .host_rx_data,
    .host_rx_ready, .host_tx_valid, .host_tx_kind, .host_tx_ack, .host_tx_data,
    .host_tx_ready, .sda_i(sda_w), .sda_o(), .sda_oe_n, .scl_i(scl_w), .scl_o(), .scl_oe_n,
    .mode_char, .heat_map, .dec_valid, .dec_kind, .dec_data, .dec_ack, .dec_err, .wave_sda,
    .wave_scl, .cap_overflow);
  iham_tgt #(.ADDR(TA)) tgt (.clk, .sda(sda_w), .scl(scl_w), .stretch(16'h0100),
    .sda_low(t_sda), .scl_low(t_scl), .last_ack, .stop_seen);
  function automatic logic [7:0] exp_rd(input logic [7:0] i);
    return i ^ 8'h5a;
  endfunction
  task automatic results();
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] b);
    int i;
    host_rx_valid = 1;
    host_rx_data = b;
    for (i = 0; i < 40000 && host_rx_ready !== 1'b1; i++)
      w(1);
    if (i == 40000)
    begin
      bad_count++;
      results();
    end
    w(1);
    host_rx_valid = 0;
    w(1);
  endtask
  task automatic get(input int lim);
    for (int i = 0; i < lim && host_tx_valid !== 1'b1; i++)
      w(1);
    ok = host_tx_valid === 1'b1;
    wd = {host_tx_kind, host_tx_ack, host_tx_data};
    host_tx_ready = ok;
    w(1);
    host_tx_ready = 0;
    w(1);
  endtask
  task automatic reply(input logic [10:0] e);
    get(40000);
    if (!ok)
    begin
      bad_count++;
      results();
    end
    chk({1'b0, wd}, {1'b0, e});
  endtask
  // Bench-side controller on the wire, half period of six core clocks
  task automatic bit1(input logic b);
    b_sda = !b;
    w(3);
    b_scl = 0;
    w(6);
    b_scl = 1;
    w(3);
  endtask
  task automatic bstart();
    b_sda = 1;
    w(6);
    b_scl = 1;
    w(3);
  endtask
  task automatic bstop();
    b_sda = 1;
    w(3);
    b_scl = 0;
    w(6);
    b_sda = 0;
    w(6);
    eq.push_back({1'b0, KIND_STOP, 1'b0, 8'h00});
  endtask
  task automatic bbyte(input logic [7:0] b, input logic a, input logic [1:0] k, input logic e);
    for (int i = 7; i >= 0; i--)
      bit1(b[i]);
    bit1(a);
    eq.push_back({e, k, a, b});
  endtask
  // A stop carries no acknowledge, so that bit is left out of its comparison
  task automatic cmpq(input int n, input logic [11:0] mk);
    for (int i = 0; i < n; i++)
      chk(dq[i] & mk & (eq[i][10:9] == KIND_STOP ? 12'heff : 12'hfff), eq[i] & mk);
  endtask
  always @(negedge clk)
    if (dec_valid === 1'b1)
      dq.push_back({dec_err, dec_kind, dec_ack, dec_data});
  always @(negedge clk)
    if (passive && (sda_oe_n !== 1'b1 || scl_oe_n !== 1'b1))
      chk(12'h000, 12'h001);
  initial
  begin
    w(8);
    rst = 0;
    w(2);
    chk({mode_char, 2'b00, sda_oe_n, scl_oe_n}, {CH_DRV, 4'h3});
    idx = 8'($random(seed));
    put(CMD_START);
    put({TA, 1'b0});
    reply({KIND_REPLY, 1'b0, 8'h00});
    put({CMD_WR_TOP, 6'h00});
    put(idx);
    put(CMD_START);
    put({TA, 1'b1});
    reply({KIND_REPLY, 1'b0, 8'h00});
    put({CMD_RD_TOP, 6'h01});
    reply({KIND_REPLY, 1'b0, exp_rd(idx)});
    reply({KIND_REPLY, 1'b1, exp_rd(idx + 8'h01)});
    chk(12'(last_ack), 12'h001);
    put(CMD_STOP);
    for (int i = 0; i < 5000 && stop_seen !== 1'b1; i++)
      w(1);
    chk(12'(stop_seen), 12'h001);
    // Register write of two values, then a register read of both from the same index
    ri = 8'($random(seed));
    v1 = 8'($random(seed));
    v2 = 8'($random(seed));
    put(CMD_REGWR);
    put({1'b0, TA});
    put(ri);
    put(8'h02);
    put(v1);
    put(v2);
    put(CMD_REGRD);
    put({1'b0, TA});
    put(ri);
    put(8'h02);
    reply({KIND_REPLY, 1'b0, v1});
    reply({KIND_REPLY, 1'b1, v2});
    for (int i = 0; i < 5000 && stop_seen !== 1'b1; i++)
      w(1);
    chk(12'(stop_seen), 12'h001);
    put(CMD_MON);
    chk(12'(mode_char), 12'(CH_MON));
    passive = 1;
    dq.delete();
    eq.delete();
    bstart();
    bbyte(8'h91, 0, KIND_START, 0);
    w(3);
    chk(12'(heat_map[8'h40]), 12'(HEAT_WHITE));
    chk(12'({wave_sda, wave_scl}), 12'({sda_w, scl_w}));
    bbyte(8'($random(seed)), 0, KIND_BYTE, 0);
    bbyte(8'($random(seed)), 1, KIND_BYTE, 0);
    bstop();
    bstart();
    bbyte(8'h20, 1, KIND_START, 1);
    bstop();
    w(4);
    chk(12'(dq.size()), 12'(eq.size()));
    cmpq(eq.size(), 12'hfff);
    put(8'($random(seed)));
    chk(12'(mode_char), 12'(CH_DRV));
    w(5000);
    chk(12'(heat_map[8'h40]), 12'(HEAT_BLUE));
    put(CMD_CAP);
    chk(12'(mode_char), 12'(CH_CAP));
    eq.delete();
    bstart();
    bbyte(8'h28, 0, KIND_START, 0);
    repeat (20)
      bbyte(8'($random(seed)), 0, KIND_BYTE, 0);
    bstop();
    w(4);
    chk(12'(cap_overflow), 12'h001);
    dq.delete();
    ok = 1;
    while (ok && dq.size() < 40)
    begin
      get(20);
      if (ok)
        dq.push_back({1'b0, wd});
    end
    chk(12'(dq.size() >= 16), 12'h001);
    cmpq(16, 12'h7ff);
    put(8'($random(seed)));
    chk(12'(mode_char), 12'(CH_DRV));
    results();
  end
endmodule
`default_nettype wire
